// file: sci_pkg.sv
// constants, register indices and carrier types for the socket command and event block
// assumes one socket instance per package user; indices become byte addresses times four
package sci_pkg;

  localparam int SCI_ADDR_W = 18;
  localparam int SCI_IDX_LSB = 2;

  // register indices, byte address is four times the index
  localparam logic [15:0] SCI_IDX_MODE = 16'h8200;
  localparam logic [15:0] SCI_IDX_CMD = 16'h8202;
  localparam logic [15:0] SCI_IDX_MASK = 16'h8204;
  localparam logic [15:0] SCI_IDX_FLAGS = 16'h8206;
  localparam logic [15:0] SCI_IDX_STATE = 16'h8208;
  localparam logic [15:0] SCI_IDX_KA = 16'h8210;
  localparam logic [15:0] SCI_IDX_DHAR0 = 16'h8212;
  localparam logic [15:0] SCI_IDX_DHAR1 = 16'h8214;
  localparam logic [15:0] SCI_IDX_DHAR2 = 16'h8216;
  localparam logic [15:0] SCI_IDX_GEN = 16'h8218;
  localparam logic [15:0] SCI_IDX_GPEND = 16'h821a;

  // command codes
  localparam logic [7:0] SCI_CMD_FIXED_SEND = 8'h21;
  localparam logic [7:0] SCI_CMD_KEEPALIVE = 8'h22;
  localparam logic [7:0] SCI_CMD_PPP_UP = 8'h23;
  localparam logic [7:0] SCI_CMD_PPP_DOWN = 8'h24;
  localparam logic [7:0] SCI_CMD_PPP_REQ = 8'h25;
  localparam logic [7:0] SCI_CMD_PPP_NAK = 8'h26;
  localparam logic [7:0] SCI_CMD_PPP_REJ = 8'h27;
  localparam logic [7:0] SCI_CMD_RX_CONSUMED = 8'h40;

  // protocol selection in the low nibble of the mode field
  localparam logic [3:0] SCI_MODE_TCP = 4'h1;
  localparam logic [3:0] SCI_MODE_UDP = 4'h2;
  localparam logic [3:0] SCI_MODE_IPRAW = 4'h3;
  localparam logic [3:0] SCI_MODE_MACRAW = 4'h4;
  localparam logic [3:0] SCI_MODE_PPPOE = 4'h5;

  // socket state codes
  localparam logic [7:0] SCI_STATE_RELEASED = 8'h00;
  localparam logic [7:0] SCI_STATE_CONNECTED = 8'h17;

  // event bit positions
  localparam int SCI_BIT_LINK_UP = 0;
  localparam int SCI_BIT_PEER_FIN = 1;
  localparam int SCI_BIT_RECEIVE = 2;
  localparam int SCI_BIT_TIMEOUT = 3;
  localparam int SCI_BIT_SEND_DONE = 4;
  localparam logic [7:0] SCI_PPP_BITS = 8'he0;

  localparam logic [7:0] SCI_MASK_RESET = 8'hff;
  localparam logic [7:0] SCI_FLAGS_RESET = 8'h00;
  localparam logic [7:0] SCI_KA_RESET = 8'h00;

  localparam logic [1:0] SCI_RESP_OKAY = 2'b00;
  localparam logic [1:0] SCI_RESP_SLVERR = 2'b10;

  // pulses and levels coming back from the protocol engine
  typedef struct packed {
    logic ka_ack;
    logic ka_fail;
    logic data_xfer;
    logic send_done;
    logic [7:0] events;
  } sci_evt_t;

  // one-cycle action pulses towards the protocol engine
  typedef struct packed {
    logic send_fixed;
    logic ka_probe;
    logic rx_consumed;
    logic ppp_up;
    logic ppp_down;
    logic ppp_req;
    logic ppp_nak;
    logic ppp_rej;
  } sci_act_t;

  typedef enum logic [1:0] {
    SCI_KA_IDLE = 2'b01,
    SCI_KA_WAIT = 2'b10
  } sci_ka_t;

endpackage : sci_pkg

// file: sci_socket_cmd.sv
// socket command interpreter with event flags, event mask and interrupt roll-up
// assumes an axi4-lite master on aclk and a protocol engine answering the action pulses
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module sci_socket_cmd #(
  parameter int SOCKET_INDEX = 0,
  parameter int KA_TICK_CYCLES = 100
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [sci_pkg::SCI_ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [sci_pkg::SCI_ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // protocol engine
  input wire sci_pkg::sci_evt_t evt,
  input wire logic state_wr,
  input wire logic [7:0] state_val,
  output sci_pkg::sci_act_t act,
  output logic [47:0] dest_hw_addr_reg,
  // host interrupt
  output logic interrupt_n
);
  import sci_pkg::*;

  localparam int TICK_W = (KA_TICK_CYCLES > 1) ? $clog2(KA_TICK_CYCLES) : 1;

  if (SOCKET_INDEX < 0 || SOCKET_INDEX > 7) begin : g_bad_socket
    $error("socket index out of range");
  end
  if (KA_TICK_CYCLES < 1) begin : g_bad_tick
    $error("keepalive tick must be at least one cycle");
  end

  logic [7:0] socket_mode_field;
  logic [7:0] socket_event_mask;
  logic [7:0] socket_event_flags;
  logic [7:0] socket_state;
  logic [7:0] keepalive_interval;
  logic global_socket_enable;
  logic global_socket_pending;
  logic [SCI_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic data_seen;
  logic [TICK_W-1:0] tick_cnt;
  logic ka_tick;
  logic [7:0] idle_ticks;
  sci_ka_t ka_st;
  sci_act_t next_act;
  logic [7:0] next_flags;

  // ---------------- bus slave ----------------
  logic wr_fire;
  logic [15:0] wr_idx;
  logic wr_ok;
  logic [15:0] rd_idx;
  logic rd_ok;
  logic [31:0] rd_word;

  assign wr_fire = !s_awready && !s_wready && !s_bvalid;
  assign wr_idx = aw_addr[SCI_IDX_LSB +: 16];
  assign rd_idx = s_araddr[SCI_IDX_LSB +: 16];

  // map check, misaligned or unknown addresses answer slverr
  function automatic logic idx_known(input logic [15:0] idx, input logic [1:0] low);
    idx_known = (low == 2'b00) &&
      (idx == SCI_IDX_MODE || idx == SCI_IDX_CMD || idx == SCI_IDX_MASK || idx == SCI_IDX_FLAGS ||
       idx == SCI_IDX_STATE || idx == SCI_IDX_KA || idx == SCI_IDX_DHAR0 || idx == SCI_IDX_DHAR1 ||
       idx == SCI_IDX_DHAR2 || idx == SCI_IDX_GEN || idx == SCI_IDX_GPEND);
  endfunction : idx_known

  assign wr_ok = idx_known(wr_idx, aw_addr[1:0]);
  assign rd_ok = idx_known(rd_idx, s_araddr[1:0]);

  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      SCI_IDX_MODE: rd_word[7:0] = socket_mode_field;
      SCI_IDX_MASK: rd_word[7:0] = socket_event_mask;
      SCI_IDX_FLAGS: rd_word[7:0] = socket_event_flags;
      SCI_IDX_STATE: rd_word[7:0] = socket_state;
      SCI_IDX_KA: rd_word[7:0] = keepalive_interval;
      SCI_IDX_DHAR0: rd_word[15:0] = dest_hw_addr_reg[47:32];
      SCI_IDX_DHAR1: rd_word[15:0] = dest_hw_addr_reg[31:16];
      SCI_IDX_DHAR2: rd_word[15:0] = dest_hw_addr_reg[15:0];
      SCI_IDX_GEN: rd_word[0] = global_socket_enable;
      SCI_IDX_GPEND: rd_word[0] = global_socket_pending;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= SCI_RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_awready && s_awvalid) begin
        s_awready <= 1'b0;
        aw_addr <= s_awaddr;
      end
      if (s_wready && s_wvalid) begin
        s_wready <= 1'b0;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? SCI_RESP_OKAY : SCI_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= SCI_RESP_OKAY;
    end else if (s_arready && s_arvalid) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_word;
      s_rresp <= rd_ok ? SCI_RESP_OKAY : SCI_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ---------------- configuration registers ----------------
  logic lo_wr;
  logic hi_wr;
  assign lo_wr = wr_fire && w_strb[0];
  assign hi_wr = wr_fire && w_strb[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      socket_mode_field <= 8'h00;
      socket_event_mask <= SCI_MASK_RESET;
      keepalive_interval <= SCI_KA_RESET;
      global_socket_enable <= 1'b0;
    end else if (lo_wr) begin
      if (wr_idx == SCI_IDX_MODE) begin
        socket_mode_field <= w_data[7:0];
      end
      if (wr_idx == SCI_IDX_MASK) begin
        socket_event_mask <= w_data[7:0];
      end
      if (wr_idx == SCI_IDX_KA) begin
        keepalive_interval <= w_data[7:0];
      end
      if (wr_idx == SCI_IDX_GEN) begin
        global_socket_enable <= w_data[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dest_hw_addr_reg <= 48'h0000_0000_0000;
    end else begin
      if (lo_wr && wr_idx == SCI_IDX_DHAR0) dest_hw_addr_reg[39:32] <= w_data[7:0];
      if (hi_wr && wr_idx == SCI_IDX_DHAR0) dest_hw_addr_reg[47:40] <= w_data[15:8];
      if (lo_wr && wr_idx == SCI_IDX_DHAR1) dest_hw_addr_reg[23:16] <= w_data[7:0];
      if (hi_wr && wr_idx == SCI_IDX_DHAR1) dest_hw_addr_reg[31:24] <= w_data[15:8];
      if (lo_wr && wr_idx == SCI_IDX_DHAR2) dest_hw_addr_reg[7:0] <= w_data[7:0];
      if (hi_wr && wr_idx == SCI_IDX_DHAR2) dest_hw_addr_reg[15:8] <= w_data[15:8];
    end
  end

  // ---------------- command decode ----------------
  logic cmd_wr;
  logic [7:0] cmd_code;
  logic is_tcp;
  logic is_udp_raw;
  logic ppp_ok;
  logic is_open;
  logic is_connected;
  logic auto_probe;

  assign cmd_wr = lo_wr && wr_idx == SCI_IDX_CMD;
  assign cmd_code = w_data[7:0];
  assign is_tcp = socket_mode_field[3:0] == SCI_MODE_TCP;
  assign is_udp_raw = socket_mode_field[3:0] == SCI_MODE_UDP || socket_mode_field[3:0] == SCI_MODE_IPRAW;
  assign ppp_ok = SOCKET_INDEX == 0 && socket_mode_field[3:0] == SCI_MODE_PPPOE;
  assign is_open = socket_state != SCI_STATE_RELEASED;
  assign is_connected = socket_state == SCI_STATE_CONNECTED;

  always_comb begin
    next_act = '0;
    if (cmd_wr) begin
      case (cmd_code)
        SCI_CMD_FIXED_SEND: next_act.send_fixed = is_udp_raw && is_open;
        SCI_CMD_KEEPALIVE: next_act.ka_probe = is_tcp && is_connected && data_seen &&
                                               keepalive_interval == SCI_KA_RESET && ka_st == SCI_KA_IDLE;
        SCI_CMD_RX_CONSUMED: next_act.rx_consumed = is_open;
        SCI_CMD_PPP_UP: next_act.ppp_up = ppp_ok;
        SCI_CMD_PPP_DOWN: next_act.ppp_down = ppp_ok;
        SCI_CMD_PPP_REQ: next_act.ppp_req = ppp_ok;
        SCI_CMD_PPP_NAK: next_act.ppp_nak = ppp_ok;
        SCI_CMD_PPP_REJ: next_act.ppp_rej = ppp_ok;
        default: next_act = '0;
      endcase
    end
    if (auto_probe) begin
      next_act.ka_probe = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act <= '0;
    end else begin
      act <= next_act;
    end
  end

  // ---------------- keepalive ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= '0;
      ka_tick <= 1'b0;
    end else if (tick_cnt == TICK_W'(KA_TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      ka_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      ka_tick <= 1'b0;
    end
  end

  // data exchange seen on this connection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_seen <= 1'b0;
    end else if (!is_open) begin
      data_seen <= evt.data_xfer;
    end else if (evt.data_xfer) begin
      data_seen <= 1'b1;
    end
  end

  assign auto_probe = is_tcp && is_connected && data_seen && keepalive_interval != SCI_KA_RESET &&
                      ka_st == SCI_KA_IDLE && ka_tick && idle_ticks >= keepalive_interval && !cmd_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_ticks <= 8'h00;
    end else if (evt.data_xfer || next_act.ka_probe || !is_connected) begin
      idle_ticks <= 8'h00;
    end else if (ka_tick && idle_ticks != 8'hff) begin
      idle_ticks <= idle_ticks + 1'b1;
    end
  end

  logic ka_failed;
  assign ka_failed = ka_st == SCI_KA_WAIT && evt.ka_fail;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ka_st <= SCI_KA_IDLE;
    end else begin
      case (ka_st)
        SCI_KA_IDLE: if (next_act.ka_probe) ka_st <= SCI_KA_WAIT;
        // ack returns to idle, state untouched
        SCI_KA_WAIT: if (evt.ka_ack || evt.ka_fail) ka_st <= SCI_KA_IDLE;
        default: ka_st <= SCI_KA_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      socket_state <= SCI_STATE_RELEASED;
    end else if (ka_failed) begin
      socket_state <= SCI_STATE_RELEASED;
    end else if (state_wr) begin
      socket_state <= state_val;
    end
  end

  // ---------------- event flags ----------------
  logic [7:0] raw_evt;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] next_mask;

  always_comb begin
    raw_evt = evt.events;
    raw_evt[SCI_BIT_TIMEOUT] = evt.events[SCI_BIT_TIMEOUT] || ka_failed;
    raw_evt[SCI_BIT_SEND_DONE] = evt.events[SCI_BIT_SEND_DONE] || evt.send_done;
  end

  assign set_vec = raw_evt & socket_event_mask & (ppp_ok ? 8'hff : ~SCI_PPP_BITS);
  assign clr_vec = (lo_wr && wr_idx == SCI_IDX_FLAGS) ? w_data[7:0] : 8'h00;
  // set wins over a same-cycle clear
  assign next_flags = (socket_event_flags & ~clr_vec) | set_vec;
  // mask as it stands after this edge, so pending tracks a mask write
  assign next_mask = (lo_wr && wr_idx == SCI_IDX_MASK) ? w_data[7:0] : socket_event_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      socket_event_flags <= SCI_FLAGS_RESET;
    end else begin
      socket_event_flags <= next_flags;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_socket_pending <= 1'b0;
    end else begin
      global_socket_pending <= |(next_flags & next_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_n <= 1'b1;
    end else begin
      interrupt_n <= !(global_socket_pending && global_socket_enable);
    end
  end

  // ---------------- checks ----------------
  AST_FIXED_SEND: assert property (@(posedge aclk) disable iff (!aresetn)
    act.send_fixed |-> $past(cmd_wr && cmd_code == SCI_CMD_FIXED_SEND && is_udp_raw))
    else $error("fixed send outside udp or raw mode");
  AST_KA_TCP: assert property (@(posedge aclk) disable iff (!aresetn)
    act.ka_probe |-> $past(is_tcp && is_connected && data_seen))
    else $error("keepalive probe without tcp connection and data");
  AST_KA_IGNORE: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmd_wr && cmd_code == SCI_CMD_KEEPALIVE && keepalive_interval != SCI_KA_RESET) |=> !act.ka_probe)
    else $error("manual keepalive honoured with nonzero interval");
  AST_KA_FAIL: assert property (@(posedge aclk) disable iff (!aresetn)
    ka_failed |=> socket_state == SCI_STATE_RELEASED && (socket_event_flags[SCI_BIT_TIMEOUT] ||
                                                         !$past(socket_event_mask[SCI_BIT_TIMEOUT])))
    else $error("failed probe did not release socket");
  AST_KA_ACK: assert property (@(posedge aclk) disable iff (!aresetn)
    (ka_st == SCI_KA_WAIT && evt.ka_ack && !evt.ka_fail && !state_wr) |=> socket_state == $past(socket_state))
    else $error("acknowledged probe changed state");
  AST_SET_MASKED: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (socket_event_flags & ~$past(socket_event_flags) & ~$past(socket_event_mask)) == 8'h00)
    else $error("flag set while masked out");
  AST_PPP_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    !ppp_ok |=> (socket_event_flags & ~$past(socket_event_flags) & SCI_PPP_BITS) == 8'h00)
    else $error("ppp flag set outside pppoe socket");
  AST_PENDING: assert property (@(posedge aclk) disable iff (!aresetn)
    global_socket_pending == |(socket_event_flags & socket_event_mask))
    else $error("pending disagrees with masked flags");
  AST_IRQ: assert property (@(posedge aclk) disable iff (!aresetn)
    (global_socket_pending && global_socket_enable) |=> !interrupt_n)
    else $error("interrupt not asserted");
  AST_W1C: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr_vec != 8'h00) |=> (socket_event_flags & $past(clr_vec) & ~$past(set_vec)) == 8'h00)
    else $error("written one did not clear flag");
  AST_SEND_DONE: assert property (@(posedge aclk) disable iff (!aresetn)
    (evt.send_done && socket_event_mask[SCI_BIT_SEND_DONE]) |=> socket_event_flags[SCI_BIT_SEND_DONE])
    else $error("send completion not flagged");
  AST_PPP_CMD: assert property (@(posedge aclk) disable iff (!aresetn)
    (act.ppp_up || act.ppp_down || act.ppp_req || act.ppp_nak || act.ppp_rej) |-> $past(ppp_ok))
    else $error("ppp command outside pppoe socket");

  COV_FIXED: cover property (@(posedge aclk) disable iff (!aresetn) act.send_fixed);
  COV_AUTO_KA: cover property (@(posedge aclk) disable iff (!aresetn) auto_probe ##[1:50] evt.ka_ack);
  COV_KA_FAIL: cover property (@(posedge aclk) disable iff (!aresetn) ka_failed);
  COV_IRQ: cover property (@(posedge aclk) disable iff (!aresetn) $fell(interrupt_n));

endmodule : sci_socket_cmd

// file: sci_engine_model.sv
// protocol engine stand-in: answers probes and fixed sends, relays bench events
// assumes act pulses from sci_socket_cmd on aclk; slow stretches every answer
`timescale 1ns/1ps
module sci_engine_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // towards the socket block
  input wire sci_pkg::sci_act_t act,
  output sci_pkg::sci_evt_t evt,
  output logic state_wr,
  output logic [7:0] state_val,
  // bench control
  input wire logic fail_mode,
  input wire logic slow,
  input wire logic [7:0] ev_in,
  input wire logic data_in,
  input wire logic st_wr_in,
  input wire logic [7:0] st_in
);
  import sci_pkg::*;
  logic ka_pend;
  logic sd_pend;
  logic [2:0] wait_cnt;

  always_ff @(posedge aclk) begin
    evt <= '0;
    state_wr <= st_wr_in;
    state_val <= st_in;
    evt.events <= ev_in;
    evt.data_xfer <= data_in;
    if (!aresetn) begin
      ka_pend <= 1'b0;
      sd_pend <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (act.ka_probe || act.send_fixed) begin
      ka_pend <= act.ka_probe;
      sd_pend <= act.send_fixed;
      wait_cnt <= slow ? 3'h5 : 3'h0;
    end else if (wait_cnt != 3'h0) begin
      wait_cnt <= wait_cnt - 3'h1;
    end else begin
      // probe answered by ack or failure
      evt.ka_ack <= ka_pend && !fail_mode;
      evt.ka_fail <= ka_pend && fail_mode;
      evt.send_done <= sd_pend;
      ka_pend <= 1'b0;
      sd_pend <= 1'b0;
    end
  end
endmodule : sci_engine_model

// file: tb_top.sv
// bench for sci_socket_cmd: axi4-lite register tasks, engine model, act pulse monitor
// assumes KA_TICK_CYCLES is shortened to 4 so automatic probes come quickly
`timescale 1ns/1ps
module tb_top;
  import sci_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, interrupt_n, state_wr;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] state_val;
  logic [47:0] dhar;
  sci_evt_t evt;
  sci_act_t act;
  logic fail_mode = 1'b0, slow = 1'b0, data_in = 1'b0, st_wr_in = 1'b0, act_clr = 1'b0;
  logic [7:0] ev_in = '0, st_in = '0, act_seen = '0;
  logic [31:0] rd_d;
  logic [1:0] rd_r;
  logic [1:0] wr_r;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 aclk = ~aclk;

  sci_socket_cmd #(.SOCKET_INDEX(0), .KA_TICK_CYCLES(4)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .evt(evt), .state_wr(state_wr), .state_val(state_val),
    .act(act), .dest_hw_addr_reg(dhar), .interrupt_n(interrupt_n));

  sci_engine_model i_eng (.aclk(aclk), .aresetn(aresetn), .act(act), .evt(evt), .state_wr(state_wr),
    .state_val(state_val), .fail_mode(fail_mode), .slow(slow), .ev_in(ev_in), .data_in(data_in),
    .st_wr_in(st_wr_in), .st_in(st_in));

  // sticky record of action pulses
  always @(posedge aclk) begin
    act_seen <= act_clr ? 8'h00 : (act_seen | act);
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      error_cnt = error_cnt + 1;
    end
  endtask : chk

  task wr(input logic [15:0] idx, input logic [31:0] d);
    awaddr <= {idx, 2'b00};
    wdata <= d;
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    wr_r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task rd(input logic [15:0] idx);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task rchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
    rd(idx);
    chk(name, {16'h0000, exp}, {16'h0000, rd_d});
  endtask : rchk

  task pulse_ev(input logic [7:0] ev, input logic data, input logic st, input logic [7:0] sv);
    ev_in <= ev;
    data_in <= data;
    st_wr_in <= st;
    st_in <= sv;
    @(posedge aclk);
    ev_in <= 8'h00;
    data_in <= 1'b0;
    st_wr_in <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_ev

  // issue a command and compare the action pulses it caused
  task cmd(input logic [7:0] code, input logic [7:0] exp);
    act_clr <= 1'b1;
    @(posedge aclk);
    act_clr <= 1'b0;
    wr(SCI_IDX_CMD, {24'h000000, code});
    repeat (10) @(posedge aclk);
    chk("act", {40'h0, exp}, {40'h0, act_seen});
  endtask : cmd

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk("mask_rst", SCI_IDX_MASK, 32'h000000ff);
    rchk("flags_rst", SCI_IDX_FLAGS, 32'h00000000);
    rchk("state_rst", SCI_IDX_STATE, 32'h00000000);
    rd(16'h8220);
    chk("bad_resp", {46'h0, SCI_RESP_SLVERR}, {46'h0, rd_r});
    chk("bad_data", 48'h0, {16'h0000, rd_d});
    wr(16'h8220, 32'h000000ff);
    chk("bad_wresp", {46'h0, SCI_RESP_SLVERR}, {46'h0, wr_r});
    wr(SCI_IDX_MASK, 32'h00000000);
    chk("wresp", {46'h0, SCI_RESP_OKAY}, {46'h0, wr_r});
    pulse_ev(8'h04, 1'b0, 1'b0, 8'h00);
    rchk("flags_masked", SCI_IDX_FLAGS, 32'h00000000);
    wr(SCI_IDX_MASK, 32'h00000004);
    pulse_ev(8'h06, 1'b0, 1'b0, 8'h00);
    rchk("flags_set", SCI_IDX_FLAGS, 32'h00000004);
    rchk("pend_set", SCI_IDX_GPEND, 32'h00000001);
    chk("int_off", 48'h1, {47'h0, interrupt_n});
    wr(SCI_IDX_GEN, 32'h00000001);
    repeat (2) @(posedge aclk);
    chk("int_on", 48'h0, {47'h0, interrupt_n});
    wr(SCI_IDX_FLAGS, 32'h000000fb);
    rchk("flags_keep", SCI_IDX_FLAGS, 32'h00000004);
    wr(SCI_IDX_FLAGS, 32'h00000004);
    rchk("flags_clr", SCI_IDX_FLAGS, 32'h00000000);
    rchk("pend_clr", SCI_IDX_GPEND, 32'h00000000);
    chk("int_clr", 48'h1, {47'h0, interrupt_n});
    wr(SCI_IDX_MASK, 32'h000000ff);
    wr(SCI_IDX_MODE, {28'h0, SCI_MODE_TCP});
    pulse_ev(8'he0, 1'b0, 1'b0, 8'h00);
    rchk("ppp_bits_tcp", SCI_IDX_FLAGS, 32'h00000000);
    for (int c = 8'h23; c <= 8'h27; c++) cmd(c[7:0], 8'h00);
    wr(SCI_IDX_MODE, {28'h0, SCI_MODE_PPPOE});
    pulse_ev(8'he0, 1'b0, 1'b0, 8'h00);
    rchk("ppp_bits", SCI_IDX_FLAGS, 32'h000000e0);
    wr(SCI_IDX_FLAGS, 32'h000000e0);
    for (int c = 8'h23; c <= 8'h27; c++) cmd(c[7:0], 8'h10 >> (c - 8'h23));
    cmd(8'h99, 8'h00);
    wr(SCI_IDX_DHAR0, 32'h0000a1b2);
    wr(SCI_IDX_DHAR1, 32'h0000c3d4);
    wr(SCI_IDX_DHAR2, 32'h0000e5f6);
    chk("dhar", 48'ha1b2c3d4e5f6, dhar);
    wr(SCI_IDX_MODE, {28'h0, SCI_MODE_TCP});
    pulse_ev(8'h00, 1'b0, 1'b1, SCI_STATE_CONNECTED);
    cmd(SCI_CMD_FIXED_SEND, 8'h00);
    cmd(SCI_CMD_KEEPALIVE, 8'h00);
    // host has taken the received data before consuming it
    cmd(SCI_CMD_RX_CONSUMED, 8'h20);
    wr(SCI_IDX_MODE, {28'h0, SCI_MODE_UDP});
    pulse_ev(8'h00, 1'b1, 1'b0, 8'h00);
    cmd(SCI_CMD_KEEPALIVE, 8'h00);
    slow <= 1'b1;
    cmd(SCI_CMD_FIXED_SEND, 8'h80);
    rchk("send_done", SCI_IDX_FLAGS, 32'h00000010);
    wr(SCI_IDX_FLAGS, 32'h00000010);
    wr(SCI_IDX_MODE, {28'h0, SCI_MODE_IPRAW});
    cmd(SCI_CMD_FIXED_SEND, 8'h80);
    wr(SCI_IDX_FLAGS, 32'h00000010);
    wr(SCI_IDX_MODE, {28'h0, SCI_MODE_TCP});
    cmd(SCI_CMD_KEEPALIVE, 8'h40);
    rchk("state_ack", SCI_IDX_STATE, {24'h0, SCI_STATE_CONNECTED});
    fail_mode <= 1'b1;
    // long interval keeps automatic probes away from the manual one
    wr(SCI_IDX_KA, 32'h000000ff);
    cmd(SCI_CMD_KEEPALIVE, 8'h00);
    pulse_ev(8'h00, 1'b1, 1'b0, 8'h00);
    act_clr <= 1'b1;
    @(posedge aclk);
    act_clr <= 1'b0;
    wr(SCI_IDX_KA, 32'h00000002);
    repeat (40) @(posedge aclk);
    chk("auto_probe", 48'h40, {40'h0, act_seen});
    rchk("state_fail", SCI_IDX_STATE, {24'h0, SCI_STATE_RELEASED});
    rchk("timeout_flag", SCI_IDX_FLAGS, 32'h00000008);
    end_of_test();
  end
endmodule : tb_top
